// File: rtl/pwm_evctl.sv
// Output driver, debug and event control slice of a PWM timer.
// Assumes counter core, channels and event routing sit outside on clk.
`timescale 1ns/1ps
`include "pwm_evctl_consts.svh"

// Functional notes
// - 4-bit filter on both timer event inputs
// - Per-output inversion from bits 23:16
// - Fault drives enabled outputs to fault level
// - Fault tri-states outputs without override enable
// - Debug-break bit raises fault and debug flag
// - Timer halts in debug unless run bit set
// - Software reset keeps debug control bits
// - Cycle event out enabled by bit 10
// - Retrigger event out enabled by bit 9
// - Wrap event out enabled by bit 8
// - Cycle point select field chooses event point
// - Input 1 action field decodes eight actions
// - Input 0 action field decodes eight actions
// - Channel match events gated by out enables
// - Channel incoming events gated by in enables
// - Timer event inputs gated by enable bits
// - Timer event inputs optionally inverted
module pwm_evctl (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic                           soft_reset,
	// Register port
	input  wire logic [7:0]                     reg_addr,
	input  wire logic [31:0]                    reg_wdata,
	input  wire logic                           reg_write,
	input  wire logic                           reg_read,
	output logic      [31:0]                    reg_rdata,
	// Timer state
	input  wire logic                           timer_enabled,
	input  wire logic                           write_locked,
	input  wire logic                           debug_halted,
	input  wire logic                           fault_external,
	output logic                                timer_halt,
	output logic                                fault_active,
	output logic                                debug_fault_state_flag,
	// Event inputs from routing
	input  wire logic                           timer_event_input_0,
	input  wire logic                           timer_event_input_1,
	input  wire logic [3:0]                     channel_event_in,
	output logic      [3:0]                     channel_event_accept,
	output pwm_evctl_pkg::counter_action_s      counter_action,
	// Counter core happenings and events out
	input  wire pwm_evctl_pkg::core_event_s     core_event,
	output pwm_evctl_pkg::event_out_s           event_out,
	// Waveform outputs
	input  wire logic [7:0]                     waveform_raw,
	output logic      [7:0]                     waveform_output,
	output logic      [7:0]                     waveform_output_en
);
	logic [31:0] output_driver_control;
	logic [7:0]  debug_behaviour_control;
	logic [31:0] event_io_control;
	logic [1:0]  in_sync1;
	logic [1:0]  in_sync2;
	logic [1:0]  in_filt;
	logic [1:0]  in_prev;
	logic [3:0]  filt_cnt [2];
	logic [1:0]  in_ev;
	logic [3:0]  ch_sync1;
	logic [3:0]  ch_sync2;
	logic        debug_fault;
	logic        input_fault;
	logic        next_fault;
	logic [7:0]  next_wave;
	logic [7:0]  next_wave_en;
	pwm_evctl_pkg::input0_action_e act0;
	pwm_evctl_pkg::input1_action_e act1;
	pwm_evctl_pkg::cycle_point_e   cyc_sel;
	pwm_evctl_pkg::counter_action_s next_action;
	logic        next_cycle_ev;

	// Write qualification
	function automatic logic wr_hit(input logic [7:0] ofs, input logic prot);
		wr_hit = reg_write && reg_addr == ofs && !write_locked &&
			!(prot && timer_enabled);
	endfunction

	always_ff @(posedge clk) begin
		if (rst || soft_reset) begin
			output_driver_control <= `RST_DRV;
		end else if (wr_hit(`OFS_DRV, 1'b1)) begin
			output_driver_control <= reg_wdata;
		end
	end

	// Debug control survives soft reset
	always_ff @(posedge clk) begin
		if (rst) begin
			debug_behaviour_control <= `RST_DBG;
		end else if (wr_hit(`OFS_DBG, 1'b0)) begin
			debug_behaviour_control <= {5'h00, reg_wdata[2], 1'b0,
				reg_wdata[0]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || soft_reset) begin
			event_io_control <= `RST_EVIO;
		end else if (wr_hit(`OFS_EVIO, 1'b1)) begin
			event_io_control <= {4'h0, reg_wdata[27:24], 4'h0,
				reg_wdata[19:16], reg_wdata[15:12], 1'b0,
				reg_wdata[10:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			unique case (reg_addr)
			`OFS_DRV:    reg_rdata <= output_driver_control;
			`OFS_DBG:    reg_rdata <= {24'h000000, debug_behaviour_control};
			`OFS_EVIO:   reg_rdata <= event_io_control;
			`OFS_STATUS: reg_rdata <= {29'h00000000, debug_fault,
				fault_active, timer_halt};
			default:     reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			in_sync1 <= 2'h0;
			in_sync2 <= 2'h0;
			ch_sync1 <= 4'h0;
			ch_sync2 <= 4'h0;
		end else begin
			in_sync1 <= {timer_event_input_1, timer_event_input_0};
			in_sync2 <= in_sync1;
			ch_sync1 <= channel_event_in;
			ch_sync2 <= ch_sync1;
		end
	end

	// Stable-count filters, one per input
	generate
		for (genvar i = 0; i < 2; i++) begin : g_filt
			logic [3:0] len;
			logic       raw;
			assign len = output_driver_control[`DRV_FILT0_LSB + 4*i +: 4];
			assign raw = in_sync2[i] ^
				event_io_control[`EV_INV0_BIT + i];
			always_ff @(posedge clk) begin
				if (rst) begin
					filt_cnt[i] <= 4'h0;
					in_filt[i]  <= 1'b0;
				end else if (len == 4'h0 || raw == in_filt[i]) begin
					filt_cnt[i] <= 4'h0;
					in_filt[i]  <= raw;
				end else if (filt_cnt[i] + 4'h1 >= len) begin
					filt_cnt[i] <= 4'h0;
					in_filt[i]  <= raw;
				end else begin
					filt_cnt[i] <= filt_cnt[i] + 4'h1;
				end
			end
			assign in_ev[i] = in_filt[i] && !in_prev[i] &&
				event_io_control[`EV_TCEI0_BIT + i];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			in_prev <= 2'h0;
		end else begin
			in_prev <= in_filt;
		end
	end

	assign act0 = pwm_evctl_pkg::input0_action_e'(
		event_io_control[`EV_ACT0_LSB +: 3]);
	assign act1 = pwm_evctl_pkg::input1_action_e'(
		event_io_control[`EV_ACT1_LSB +: 3]);
	assign cyc_sel = pwm_evctl_pkg::cycle_point_e'(
		event_io_control[`EV_CYCLE_EVENT_POINT_SELECT_LSB +: 2]);

	// Level faults from inputs held active while enabled
	assign input_fault =
		(act0 == pwm_evctl_pkg::ACT0_FAULT && in_filt[0] &&
		 event_io_control[`EV_TCEI0_BIT]) ||
		(act1 == pwm_evctl_pkg::ACT1_FAULT && in_filt[1] &&
		 event_io_control[`EV_TCEI1_BIT]);
	assign debug_fault = debug_halted &&
		debug_behaviour_control[`DBG_BRKFLT_BIT];

	always_comb begin
		next_action = '0;
		unique case (act0)
		pwm_evctl_pkg::ACT0_RETRG:  next_action.retrigger = in_ev[0];
		pwm_evctl_pkg::ACT0_COUNT:  next_action.count = in_ev[0];
		pwm_evctl_pkg::ACT0_START:  next_action.start = in_ev[0];
		pwm_evctl_pkg::ACT0_INC:    next_action.increment = in_ev[0];
		pwm_evctl_pkg::ACT0_ACOUNT: next_action.count_active =
			in_filt[0] && event_io_control[`EV_TCEI0_BIT];
		pwm_evctl_pkg::ACT0_STAMP:  next_action.stamp = in_ev[0];
		default: ;
		endcase
		unique case (act1)
		pwm_evctl_pkg::ACT1_RETRG: next_action.retrigger =
			next_action.retrigger | in_ev[1];
		pwm_evctl_pkg::ACT1_DIR:   next_action.direction =
			in_filt[1] && event_io_control[`EV_TCEI1_BIT];
		pwm_evctl_pkg::ACT1_STOP:  next_action.stop = in_ev[1];
		pwm_evctl_pkg::ACT1_DEC:   next_action.decrement = in_ev[1];
		pwm_evctl_pkg::ACT1_PPW:   next_action.period_pulse = in_ev[1];
		pwm_evctl_pkg::ACT1_PWP:   next_action.pulse_period = in_ev[1];
		default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			counter_action       <= '0;
			channel_event_accept <= 4'h0;
		end else begin
			counter_action       <= next_action;
			channel_event_accept <= ch_sync2 &
				event_io_control[`EV_MCEI_LSB +: 4];
		end
	end

	// Fault and halt state
	assign next_fault = input_fault || debug_fault || fault_external;
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_active           <= 1'b0;
			debug_fault_state_flag <= 1'b0;
			timer_halt             <= 1'b0;
		end else begin
			fault_active           <= next_fault;
			debug_fault_state_flag <= debug_fault;
			timer_halt             <= debug_halted &&
				!debug_behaviour_control[`DBG_RUN_BIT];
		end
	end

	always_comb begin
		unique case (cyc_sel)
		pwm_evctl_pkg::CYC_BEGIN:   next_cycle_ev = core_event.cycle_begin;
		pwm_evctl_pkg::CYC_END:     next_cycle_ev = core_event.cycle_end;
		pwm_evctl_pkg::CYC_BETWEEN: next_cycle_ev = core_event.cycle_end &&
			!core_event.last_cycle;
		pwm_evctl_pkg::CYC_BOUNDARY: next_cycle_ev =
			(core_event.cycle_begin && core_event.first_cycle) ||
			(core_event.cycle_end && core_event.last_cycle);
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			event_out <= '0;
		end else begin
			event_out.cycle     <= next_cycle_ev &&
				event_io_control[`EV_CYCLE_EVENT_OUT_ENABLE_BIT];
			event_out.retrigger <= core_event.retrigger &&
				event_io_control[`EV_RETRIGGER_EVENT_OUT_ENABLE_BIT];
			event_out.wrap      <= core_event.wrap &&
				event_io_control[`EV_WRAP_EVENT_OUT_ENABLE_BIT];
			event_out.channel   <= core_event.channel_match &
				event_io_control[`EV_MCEO_LSB +: 4];
		end
	end

	// Waveform drive, inversion then fault override
	generate
		for (genvar w = 0; w < 8; w++) begin : g_wave
			always_comb begin
				if (fault_active &&
				    output_driver_control[`DRV_NRE_LSB + w]) begin
					next_wave[w]    = output_driver_control[`DRV_NRV_LSB + w];
					next_wave_en[w] = 1'b1;
				end else if (fault_active) begin
					next_wave[w]    = 1'b0;
					next_wave_en[w] = 1'b0;
				end else begin
					next_wave[w]    = waveform_raw[w] ^
						output_driver_control[`DRV_INV_LSB + w];
					next_wave_en[w] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			waveform_output    <= 8'h00;
			waveform_output_en <= 8'h00;
		end else begin
			waveform_output    <= next_wave;
			waveform_output_en <= next_wave_en;
		end
	end

	a_drv_lock: assert property (@(posedge clk) disable iff (rst)
		reg_write && reg_addr == `OFS_DRV && timer_enabled && !soft_reset
		|=> $stable(output_driver_control))
		else $error("driver control changed while enabled");
	a_halt_dbg: assert property (@(posedge clk) disable iff (rst)
		debug_halted && !debug_behaviour_control[0] |=> timer_halt)
		else $error("timer not halted in debug");
	a_dbg_fault: assert property (@(posedge clk) disable iff (rst)
		debug_halted && debug_behaviour_control[2]
		|=> fault_active && debug_fault_state_flag)
		else $error("debug break fault missing");
	a_dbg_keep: assert property (@(posedge clk) disable iff (rst)
		soft_reset && !reg_write |=> $stable(debug_behaviour_control))
		else $error("soft reset touched debug control");
	a_wrap_gate: assert property (@(posedge clk) disable iff (rst)
		event_out.wrap |-> $past(core_event.wrap) &&
		$past(event_io_control[8]))
		else $error("wrap event without cause");
	a_trg_gate: assert property (@(posedge clk) disable iff (rst)
		core_event.retrigger && event_io_control[9] && !soft_reset
		|=> event_out.retrigger)
		else $error("retrigger event lost");
	a_chan_in: assert property (@(posedge clk) disable iff (rst)
		channel_event_accept[0] |-> $past(ch_sync2[0], 1))
		else $error("channel event accepted without input");
	a_fault_tri: assert property (@(posedge clk) disable iff (rst)
		fault_active && !output_driver_control[0] && !$changed(fault_active)
		&& $stable(output_driver_control) |=> !waveform_output_en[0])
		else $error("fault output not released");
	a_fault_lvl: assert property (@(posedge clk) disable iff (rst)
		fault_active && output_driver_control[0] && $stable(fault_active)
		|=> waveform_output_en[0] &&
		waveform_output[0] == $past(output_driver_control[8]))
		else $error("fault level wrong");

	// Four qualified high samples on input 0 at a filter length of four
	sequence s_filt_four;
		(output_driver_control[`DRV_FILT0_LSB +: 4] == 4'h4 &&
		 !event_io_control[`EV_INV0_BIT] && in_sync2[0]) [*4];
	endsequence

	a_filt_pass: assert property (@(posedge clk) disable iff (rst)
		s_filt_four |=> in_filt[0])
		else $error("filtered input not passed");
	a_filt_hold: assert property (@(posedge clk) disable iff (rst)
		output_driver_control[`DRV_FILT0_LSB +: 4] == 4'h4 &&
		!event_io_control[`EV_INV0_BIT] && !in_filt[0] && in_sync2[0] &&
		filt_cnt[0] == 4'h0 |=> !in_filt[0])
		else $error("filter passed a single sample");
	a_wave_inv: assert property (@(posedge clk) disable iff (rst)
		!fault_active |=> waveform_output_en[1] && waveform_output[1] ==
		($past(waveform_raw[1]) ^ $past(output_driver_control[17])))
		else $error("output inversion wrong");
	a_in_gate: assert property (@(posedge clk) disable iff (rst)
		!event_io_control[`EV_TCEI0_BIT] &&
		!event_io_control[`EV_TCEI1_BIT] |=> counter_action == '0)
		else $error("action from disabled input");
	a_chan_out: assert property (@(posedge clk) disable iff (rst)
		core_event.channel_match[1] && event_io_control[`EV_MCEO_LSB + 1]
		|=> event_out.channel[1])
		else $error("channel event lost");
	a_chan_mute: assert property (@(posedge clk) disable iff (rst)
		!event_io_control[`EV_MCEO_LSB] |=> !event_out.channel[0])
		else $error("channel event while disabled");
	a_cyc_off: assert property (@(posedge clk) disable iff (rst)
		!event_io_control[`EV_CYCLE_EVENT_OUT_ENABLE_BIT] |=> !event_out.cycle)
		else $error("cycle event while disabled");
endmodule

// File: rtl/pwm_evctl_consts.svh
// Offsets, field positions and reset values of the
// output, debug and event control slice. Definitions only.
`ifndef PWM_EVCTL_CONSTS_SVH
`define PWM_EVCTL_CONSTS_SVH
`define OFS_DRV          8'h18
`define OFS_DBG          8'h1e
`define OFS_EVIO         8'h20
`define OFS_STATUS       8'h30
`define RST_DRV          32'h00000000
`define RST_DBG          8'h00
`define RST_EVIO         32'h00000000
`define DRV_FILT1_LSB    28
`define DRV_FILT0_LSB    24
`define DRV_INV_LSB      16
`define DRV_NRV_LSB      8
`define DRV_NRE_LSB      0
`define DBG_BRKFLT_BIT   2
`define DBG_RUN_BIT      0
`define EV_MCEO_LSB      24
`define EV_MCEI_LSB      16
`define EV_TCEI1_BIT     15
`define EV_TCEI0_BIT     14
`define EV_INV1_BIT      13
`define EV_INV0_BIT      12
`define EV_CYCLE_EVENT_OUT_ENABLE_BIT     10
`define EV_RETRIGGER_EVENT_OUT_ENABLE_BIT     9
`define EV_WRAP_EVENT_OUT_ENABLE_BIT     8
`define EV_CYCLE_EVENT_POINT_SELECT_LSB    6
`define EV_ACT1_LSB      3
`define EV_ACT0_LSB      0
`endif

// File: rtl/pwm_evctl_pkg.sv
// Types shared by the event and output control slice.
// Assumes the constants header defines the offsets and field positions; the action and cycle point codes are defined here.
package pwm_evctl_pkg;
	typedef enum logic [1:0] {
		CYC_BEGIN    = 2'b00,
		CYC_END      = 2'b01,
		CYC_BETWEEN  = 2'b10,
		CYC_BOUNDARY = 2'b11
	} cycle_point_e;

	typedef enum logic [2:0] {
		ACT1_OFF   = 3'b000,
		ACT1_RETRG = 3'b001,
		ACT1_DIR   = 3'b010,
		ACT1_STOP  = 3'b011,
		ACT1_DEC   = 3'b100,
		ACT1_PPW   = 3'b101,
		ACT1_PWP   = 3'b110,
		ACT1_FAULT = 3'b111
	} input1_action_e;

	typedef enum logic [2:0] {
		ACT0_OFF    = 3'b000,
		ACT0_RETRG  = 3'b001,
		ACT0_COUNT  = 3'b010,
		ACT0_START  = 3'b011,
		ACT0_INC    = 3'b100,
		ACT0_ACOUNT = 3'b101,
		ACT0_STAMP  = 3'b110,
		ACT0_FAULT  = 3'b111
	} input0_action_e;

	// Action strobes toward the counter core
	typedef struct packed {
		logic retrigger;
		logic direction;
		logic stop;
		logic start;
		logic count;
		logic increment;
		logic decrement;
		logic count_active;
		logic stamp;
		logic period_pulse;
		logic pulse_period;
	} counter_action_s;

	// Counter core happenings
	typedef struct packed {
		logic       wrap;
		logic       retrigger;
		logic       cycle_begin;
		logic       cycle_end;
		logic       first_cycle;
		logic       last_cycle;
		logic [3:0] channel_match;
	} core_event_s;

	typedef struct packed {
		logic       wrap;
		logic       retrigger;
		logic       cycle;
		logic [3:0] channel;
	} event_out_s;
endpackage

// File: sim/pwm_evctl_far_end.sv
// Far side of the waveform pins: resolves each pin from the driver.
// Assumes one clock; released pins carry no pull resistor.
`timescale 1ns/1ps
module pwm_evctl_far_end (
	// Clock
	input  wire logic       clk,
	// Driver side
	input  wire logic [7:0] drive,
	input  wire logic [7:0] drive_en,
	// Pin levels
	output logic      [7:0] pin
);
	logic [7:0] last = 8'h00;

	// Floating pins flip every cycle so a stale level never passes
	always_comb begin
		pin = (drive & drive_en) | (~last & ~drive_en);
	end

	always_ff @(posedge clk) begin
		last <= pin;
	end
endmodule

// File: sim/pwm_evctl_tb_top.sv
// Self-checking bench for the output, debug and event control slice.
// Assumes rtl constants header and package are compiled first.
`timescale 1ns/1ps
`include "pwm_evctl_consts.svh"
module pwm_evctl_tb_top;
	logic                         clk = 1'b0;
	logic                         rst = 1'b1;
	logic                         soft_reset = 1'b0;
	logic [7:0]                   reg_addr = 8'h00;
	logic [31:0]                  reg_wdata = 32'h0;
	logic                         reg_write = 1'b0;
	logic                         reg_read = 1'b0;
	logic [31:0]                  reg_rdata;
	logic                         timer_enabled = 1'b0;
	logic                         write_locked = 1'b0;
	logic                         debug_halted = 1'b0;
	logic                         fault_external = 1'b0;
	logic                         timer_halt;
	logic                         fault_active;
	logic                         debug_fault_state_flag;
	logic                         tin0 = 1'b0;
	logic                         tin1 = 1'b0;
	logic [3:0]                   ch_in = 4'h0;
	logic [3:0]                   ch_acc;
	pwm_evctl_pkg::counter_action_s counter_action;
	pwm_evctl_pkg::core_event_s   core_event = '0;
	pwm_evctl_pkg::event_out_s    event_out;
	logic [7:0]                   raw = 8'h00;
	logic [7:0]                   wout;
	logic [7:0]                   wout_en;
	logic [7:0]                   pin;
	logic [11:0]                  act_v;
	logic [11:0]                  m;
	logic [31:0]                  d;
	logic [3:0]                   p;
	logic                         acc;
	int                           n_errors = 0;
	int                           n_checks = 0;
	int                           x, k, s, i;
	int                           a0 [7] = '{10, 6, 7, 5, 3, 2, 11};
	int                           a1 [7] = '{10, 9, 8, 4, 1, 0, 11};
	logic [3:0]                   pats [4] = '{4'h8, 4'h4, 4'h5, 4'ha};

	always #5 clk = ~clk;
	assign act_v = {fault_active, counter_action};

	pwm_evctl pwm_evctl_i (
		.clk(clk), .rst(rst), .soft_reset(soft_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .timer_enabled(timer_enabled),
		.write_locked(write_locked), .debug_halted(debug_halted),
		.fault_external(fault_external), .timer_halt(timer_halt),
		.fault_active(fault_active),
		.debug_fault_state_flag(debug_fault_state_flag),
		.timer_event_input_0(tin0), .timer_event_input_1(tin1),
		.channel_event_in(ch_in), .channel_event_accept(ch_acc),
		.counter_action(counter_action), .core_event(core_event),
		.event_out(event_out), .waveform_raw(raw),
		.waveform_output(wout), .waveform_output_en(wout_en)
	);

	pwm_evctl_far_end pwm_evctl_far_end_i (
		.clk(clk), .drive(wout), .drive_en(wout_en), .pin(pin)
	);

	task tally_and_finish();
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
		chk(reg_rdata, exp);
	endtask

	task wait_act(input logic [11:0] mk, input logic [11:0] v);
		int n;
		n = 0;
		while ((act_v & mk) !== v) begin
			if (n == 20) begin
				n_errors++;
				tally_and_finish();
			end
			@(posedge clk);
			n++;
		end
	endtask

	function automatic logic cyc(input int sel, input logic [3:0] c);
		case (sel)
			0: return c[3];
			1: return c[2];
			2: return c[2] & ~c[0];
			default: return (c[3] & c[1]) | (c[2] & c[0]);
		endcase
	endfunction

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_chk(`OFS_DRV, `RST_DRV);
		rd_chk(`OFS_DBG, 32'(`RST_DBG));
		rd_chk(`OFS_EVIO, `RST_EVIO);
		rd_chk(8'h04, 32'h0);
		wr(`OFS_DRV, 32'hffffffff);
		rd_chk(`OFS_DRV, 32'hffffffff);
		wr(`OFS_EVIO, 32'hffffffff);
		rd_chk(`OFS_EVIO, 32'h0f0ff7ff);
		wr(`OFS_DBG, 32'hff);
		rd_chk(`OFS_DBG, 32'h05);
		// Writes with the timer running or locked
		wr(`OFS_DBG, 32'h0);
		timer_enabled <= 1'b1;
		wr(`OFS_DRV, 32'h0);
		rd_chk(`OFS_DRV, 32'hffffffff);
		timer_enabled <= 1'b0;
		wr(`OFS_DBG, 32'h01);
		write_locked <= 1'b1;
		wr(`OFS_DBG, 32'h0);
		rd_chk(`OFS_DBG, 32'h01);
		wr(`OFS_EVIO, 32'h0);
		rd_chk(`OFS_EVIO, 32'h0f0ff7ff);
		write_locked <= 1'b0;
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		rd_chk(`OFS_DBG, 32'h01);
		rd_chk(`OFS_DRV, 32'h0);
		// Debug halt with run bit set, then cleared, then break fault
		debug_halted <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(timer_halt, 1'b0);
		wr(`OFS_DBG, 32'h0);
		repeat (2) @(posedge clk);
		#1 chk(timer_halt, 1'b1);
		chk(fault_active, 1'b0);
		wr(`OFS_DBG, 32'h04);
		repeat (2) @(posedge clk);
		#1 chk({debug_fault_state_flag, fault_active}, 2'b11);
		rd_chk(8'h30, 32'h7);
		debug_halted <= 1'b0;
		wr(`OFS_DBG, 32'h0);
		repeat (2) @(posedge clk);
		#1 chk({debug_fault_state_flag, timer_halt}, 2'b00);
		// Inversion, then fault override and tri-state
		wr(`OFS_DRV, 32'h000f5070);
		raw <= 8'ha5;
		repeat (3) @(posedge clk);
		chk({wout_en, wout}, 16'hffaa);
		fault_external <= 1'b1;
		repeat (3) @(posedge clk);
		chk(wout_en, 8'h70);
		chk(pin & 8'h70, 8'h50);
		fault_external <= 1'b0;
		wr(`OFS_DRV, 32'h0);
		// Core events, every cycle point code, enabled and not
		for (s = 0; s < 8; s++) begin
			d = (s < 4) ? 32'h06000700 : 32'h0;
			wr(`OFS_EVIO, d | (32'(s % 4) << 6));
			for (i = 0; i < 4; i++) begin
				p = pats[i];
				@(posedge clk);
				core_event <= pwm_evctl_pkg::core_event_s'({2'b11, p, 4'hf});
				@(posedge clk);
				core_event <= '0;
				#1 chk(event_out, (s < 4) ? {2'b11, cyc(s, p), 4'h6} : 7'h0);
			end
		end
		// Channel inputs gated by in enables
		wr(`OFS_EVIO, 32'h00050000);
		ch_in <= 4'hf;
		repeat (6) @(posedge clk);
		chk(ch_acc, 4'h5);
		ch_in <= 4'h0;
		// Every action code except off (1 to 7) of both timer event inputs
		for (x = 0; x < 2; x++) begin
			for (k = 1; k < 8; k++) begin
				m = 12'h1 << (x ? a1[k - 1] : a0[k - 1]);
				wr(`OFS_EVIO, (32'h1 << (14 + x)) | (32'(k) << (3 * x)));
				if (x == 1) tin1 <= 1'b1;
				else tin0 <= 1'b1;
				wait_act(m, m);
				chk(act_v, m);
				@(posedge clk);
				tin0 <= 1'b0;
				tin1 <= 1'b0;
				repeat (8) @(posedge clk);
			end
		end
		// Input enable clear: no fault
		wr(`OFS_EVIO, 32'h7);
		tin0 <= 1'b1;
		acc = 1'b0;
		repeat (10) @(posedge clk) acc |= fault_active;
		chk(acc, 1'b0);
		tin0 <= 1'b0;
		// Inverted input: low level means active
		wr(`OFS_EVIO, 32'h00005007);
		wait_act(12'h800, 12'h800);
		tin0 <= 1'b1;
		wait_act(12'h800, 12'h0);
		// Filter of four: a three-cycle glitch is dropped
		wr(`OFS_EVIO, 32'h0);
		wr(`OFS_DRV, 32'h04000000);
		wr(`OFS_EVIO, 32'h00004007);
		tin0 <= 1'b0;
		repeat (8) @(posedge clk);
		tin0 <= 1'b1;
		repeat (3) @(posedge clk);
		tin0 <= 1'b0;
		acc = 1'b0;
		repeat (12) @(posedge clk) acc |= fault_active;
		chk(acc, 1'b0);
		tin0 <= 1'b1;
		wait_act(12'h800, 12'h800);
		tally_and_finish();
	end
endmodule
